// ### hdl/ibmo_core.sv
// Branch, trap and memory-ordering decode core behind an APB slave.
// Assumes a 100 MHz pclk, APB master, memory side returning acks.
`include "ibmo_regs.svh"
// Overview of operation
// - Issue memory ops in order, complete any order
// - Sync waits until earlier accesses drain
// - Predict direction and target, steer fetch
// - Compare outcome once operands are available
// - Mispredict flushes and refetches correct path
// - Five-bit branch options select taken condition
// - Branch follows selected condition register bit
// - Eight condition register logical operations
// - Branch may decrement and test count
// - Trap condition met raises program interrupt
// - Signed and unsigned trap compares, reg or imm
// - System call interrupt at any privilege
// - Four distinct interrupt return operations
// - Condition, exception, link and count regs user; user time base user read only; others supervisor
// - Separate user and supervisor time base numbers
// - Cache ops weakly ordered until sync
// - TLB invalidate single entry or all
// - Float compare ordered, unordered, and select
// - Float convert word, dword, toward zero, single
// - Load sizes, sign, reverse, update, indexed
// - Reserving load and conditional store, indexed
module ibmo_core import ibmo_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic mem_req,
	output ibmo_memop_s mem_op,
	output logic [31:0] mem_addr,
	input wire logic mem_done,
	output logic [31:0] fetch_addr,
	output logic fetch_flush
);
	// APB state
	logic acc_w, acc_r, hit;
	logic [31:0] instr_q, opa_q, opb_q, cond_q, count_q, link_q, xer_q, pred_q, fetch_q;
	logic [31:0] cond_d, count_d;
	logic [7:0] stat_q;
	logic super_q, resv_q, go;
	logic [3:0] outst_q;
	ibmo_class_e cls;
	ibmo_memop_s mop;
	ibmo_fconv_s fconv;
	logic taken, target_ok, trap_hit, priv_fault, cr_bit, sync_block;
	logic [31:0] target;

	// Single-cycle answer; unmapped addresses error
	assign acc_w = psel & penable & pwrite;
	assign acc_r = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign hit = (paddr <= `IBMO_ADDR_CLASS) && (paddr[1:0] == 2'b00);
	assign pslverr = psel & penable & ~hit;
	assign go = acc_w && paddr == `IBMO_ADDR_CTRL && pwdata[`IBMO_CTRL_GO] && !sync_block;

	// Big-endian bit numbering: bit n of the CR is index 31-n
	function automatic logic crbit(input logic [31:0] cr, input logic [4:0] n);
		crbit = cr[5'd31 - n];
	endfunction

	// Trap compare: TO bits lt,gt,eq,ltu,gtu
	function automatic logic trap_eval(input logic [4:0] to, input logic [31:0] a,
		input logic [31:0] b);
		trap_eval = (to[4] & ($signed(a) < $signed(b))) | (to[3] & ($signed(a) > $signed(b)))
			| (to[2] & (a == b)) | (to[1] & (a < b)) | (to[0] & (a > b));
	endfunction

	// Opcode decode into classes
	always_comb begin
		cls = IBMO_C_ILLEGAL;
		mop = '0;
		fconv = '0;
		case (instr_q[31:26])
			6'd18: cls = IBMO_C_BRANCH;
			6'd16: cls = IBMO_C_BRCOND;
			6'd3: cls = IBMO_C_TRAPIMM;
			6'd17: cls = IBMO_C_SYSCALL;
			6'd32, 6'd33, 6'd34, 6'd35, 6'd40, 6'd41: begin
				cls = IBMO_C_LOAD;
				mop.valid = 1'b1;
				mop.update = instr_q[26];
				mop.size = instr_q[29] ? IBMO_SZ_HALF : (instr_q[27] ? IBMO_SZ_BYTE : IBMO_SZ_WORD);
			end
			6'd42, 6'd43: begin
				cls = IBMO_C_LOAD;
				mop.valid = 1'b1;
				mop.size = IBMO_SZ_HALF;
				mop.sign_ext = 1'b1;
				mop.update = instr_q[26];
			end
			6'd36, 6'd37, 6'd38, 6'd39, 6'd44, 6'd45: begin
				cls = IBMO_C_STORE;
				mop.valid = 1'b1;
				mop.store = 1'b1;
				mop.update = instr_q[26];
				mop.size = instr_q[29] ? IBMO_SZ_HALF : (instr_q[27] ? IBMO_SZ_BYTE : IBMO_SZ_WORD);
			end
			6'd19: begin
				case (instr_q[10:1])
					10'd16: cls = IBMO_C_BRLINK;
					10'd528: cls = IBMO_C_BRCOUNT;
					10'd50: cls = IBMO_C_RFI;
					10'd51: cls = IBMO_C_RFCI;
					10'd38: cls = IBMO_C_RFMCI;
					10'd39: cls = IBMO_C_RFDI;
					10'd150: cls = IBMO_C_ISYNC;
					10'd257, 10'd449, 10'd193, 10'd225, 10'd33, 10'd289, 10'd129, 10'd417:
						cls = IBMO_C_CRLOGIC;
					default: cls = IBMO_C_ILLEGAL;
				endcase
			end
			6'd31: begin
				case (instr_q[10:1])
					10'd4: cls = IBMO_C_TRAPREG;
					10'd339, 10'd371: cls = IBMO_C_MFSPR;
					10'd467: cls = IBMO_C_MTSPR;
					10'd83: cls = IBMO_C_MFMSR;
					10'd146: cls = IBMO_C_MTMSR;
					10'd598, 10'd854: cls = IBMO_C_SYNC;
					10'd86, 10'd54, 10'd278, 10'd1014: cls = IBMO_C_DCACHE;
					10'd306: cls = IBMO_C_TLBONE;
					10'd370: cls = IBMO_C_TLBALL;
					10'd20: begin
						cls = IBMO_C_LOADRES;
						mop.valid = 1'b1;
						mop.indexed = 1'b1;
						mop.reserve = 1'b1;
						mop.size = IBMO_SZ_WORD;
					end
					10'd150: begin
						cls = IBMO_C_STORECOND;
						mop.valid = resv_q;
						mop.store = 1'b1;
						mop.indexed = 1'b1;
						mop.size = IBMO_SZ_WORD;
					end
					10'd23, 10'd55, 10'd87, 10'd119, 10'd279, 10'd311, 10'd343, 10'd375: begin
						cls = IBMO_C_LOAD;
						mop.valid = 1'b1;
						mop.indexed = 1'b1;
						mop.update = instr_q[6];
						mop.size = instr_q[9] ? IBMO_SZ_HALF : (instr_q[7] ? IBMO_SZ_BYTE : IBMO_SZ_WORD);
						mop.sign_ext = instr_q[9] & instr_q[7];
					end
					10'd534, 10'd790: begin
						cls = IBMO_C_LOAD;
						mop.valid = 1'b1;
						mop.indexed = 1'b1;
						mop.byte_rev = 1'b1;
						mop.size = instr_q[9] ? IBMO_SZ_HALF : IBMO_SZ_WORD;
					end
					default: cls = IBMO_C_ILLEGAL;
				endcase
			end
			6'd63: begin
				case (instr_q[10:1])
					10'd0: cls = IBMO_C_FCMPU;
					10'd32: cls = IBMO_C_FCMPO;
					10'd12: cls = IBMO_C_FRSP;
					10'd14, 10'd15, 10'd814, 10'd815: begin
						cls = IBMO_C_FCONV;
						fconv.dword = instr_q[10];
						fconv.to_zero = instr_q[1];
					end
					default: cls = (instr_q[5:1] == 5'd23) ? IBMO_C_FSEL : IBMO_C_ILLEGAL;
				endcase
			end
			default: cls = IBMO_C_ILLEGAL;
		endcase
	end

	// Branch condition from the options field and selected CR bit
	always_comb begin
		cr_bit = crbit(cond_q, instr_q[20:16]);
		count_d = count_q;
		if (!instr_q[23]) begin
			count_d = count_q - 32'h0000_0001;
		end
		// Options: bit4 ignore cond, bit3 desired value, bit2 ignore count, bit1 want zero
		taken = (instr_q[25] | (cr_bit == instr_q[24])) &
			(instr_q[23] | ((count_d == 32'h0000_0000) == instr_q[22]));
		if (cls == IBMO_C_BRANCH) begin
			taken = 1'b1;
		end
		case (cls)
			IBMO_C_BRLINK: target = {link_q[31:2], 2'b00};
			IBMO_C_BRCOUNT: target = {count_q[31:2], 2'b00};
			IBMO_C_BRANCH: target = {{6{instr_q[25]}}, instr_q[25:2], 2'b00};
			default: target = {{16{instr_q[15]}}, instr_q[15:2], 2'b00};
		endcase
		target_ok = (taken == pred_q[0]) && (!taken || target == {pred_q[31:2], 2'b00});
	end

	// CR logical ops over bits A and B into bit D
	always_comb begin
		cond_d = cond_q;
		case (instr_q[10:1])
			10'd257: cond_d[5'd31 - instr_q[25:21]] = crbit(cond_q, instr_q[20:16]) &
				crbit(cond_q, instr_q[15:11]);
			10'd449: cond_d[5'd31 - instr_q[25:21]] = crbit(cond_q, instr_q[20:16]) |
				crbit(cond_q, instr_q[15:11]);
			10'd193: cond_d[5'd31 - instr_q[25:21]] = crbit(cond_q, instr_q[20:16]) ^
				crbit(cond_q, instr_q[15:11]);
			10'd225: cond_d[5'd31 - instr_q[25:21]] = ~(crbit(cond_q, instr_q[20:16]) &
				crbit(cond_q, instr_q[15:11]));
			10'd33: cond_d[5'd31 - instr_q[25:21]] = ~(crbit(cond_q, instr_q[20:16]) |
				crbit(cond_q, instr_q[15:11]));
			10'd289: cond_d[5'd31 - instr_q[25:21]] = ~(crbit(cond_q, instr_q[20:16]) ^
				crbit(cond_q, instr_q[15:11]));
			10'd129: cond_d[5'd31 - instr_q[25:21]] = crbit(cond_q, instr_q[20:16]) &
				~crbit(cond_q, instr_q[15:11]);
			10'd417: cond_d[5'd31 - instr_q[25:21]] = crbit(cond_q, instr_q[20:16]) |
				~crbit(cond_q, instr_q[15:11]);
			default: cond_d = cond_q;
		endcase
	end

	// Trap and privilege checks
	always_comb begin
		trap_hit = 1'b0;
		if (cls == IBMO_C_TRAPREG) begin
			trap_hit = trap_eval(instr_q[25:21], opa_q, opb_q);
		end else if (cls == IBMO_C_TRAPIMM) begin
			trap_hit = trap_eval(instr_q[25:21], opa_q, {{16{instr_q[15]}}, instr_q[15:0]});
		end
		priv_fault = 1'b0;
		case (cls)
			IBMO_C_RFI, IBMO_C_RFCI, IBMO_C_RFMCI, IBMO_C_RFDI, IBMO_C_MFMSR, IBMO_C_MTMSR,
			IBMO_C_TLBONE, IBMO_C_TLBALL: priv_fault = !super_q;
			IBMO_C_MFSPR, IBMO_C_MTSPR: begin
				// Count, link and exception stay open to user code; user time base is open to reads only
				priv_fault = !super_q && !({instr_q[15:11], instr_q[20:16]} inside
					{`IBMO_SPR_XER, `IBMO_SPR_LINK, `IBMO_SPR_COUNT}) &&
					!(cls == IBMO_C_MFSPR && {instr_q[15:11], instr_q[20:16]} ==
					`IBMO_SPR_TB_USER);
			end
			default: priv_fault = 1'b0;
		endcase
	end

	// Sync holds execution while accesses remain outstanding
	assign sync_block = (cls == IBMO_C_SYNC || cls == IBMO_C_ISYNC) && outst_q != 4'h0;

	// Memory issue: one op per go, in order; completions counted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req <= 1'b0;
			mem_op <= '0;
			mem_addr <= 32'h0000_0000;
		end else begin
			mem_req <= go && mop.valid && !priv_fault && outst_q != `IBMO_OUTSTANDING_MAX;
			mem_op <= mop;
			mem_addr <= (mop.indexed ? opa_q + opb_q : opa_q + {{16{instr_q[15]}}, instr_q[15:0]});
		end
	end

	// Outstanding count; done pulses may arrive in any order
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			outst_q <= 4'h0;
		end else begin
			outst_q <= outst_q + {3'h0, mem_req} - {3'h0, mem_done && outst_q != 4'h0};
		end
	end

	// Reservation for the reserving load / conditional store pair
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resv_q <= 1'b0;
		end else if (go && (cls == IBMO_C_LOADRES)) begin
			resv_q <= 1'b1;
		end else if (go && (cls == IBMO_C_STORECOND)) begin
			resv_q <= 1'b0;
		end
	end

	// Fetch steering and recovery
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_q <= `IBMO_RST_FETCH;
			fetch_flush <= 1'b0;
		end else begin
			fetch_flush <= 1'b0;
			if (acc_w && paddr == `IBMO_ADDR_PRED) begin
				fetch_q <= pwdata[0] ? {pwdata[31:2], 2'b00} : fetch_q;
			end else if (go && cls inside {IBMO_C_BRANCH, IBMO_C_BRCOND, IBMO_C_BRLINK,
				IBMO_C_BRCOUNT} && !target_ok) begin
				fetch_flush <= 1'b1;
				fetch_q <= taken ? target : fetch_q + 32'h0000_0004;
			end
		end
	end
	assign fetch_addr = fetch_q;

	// Architected registers and status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_q <= 32'h0000_0000;
			opa_q <= 32'h0000_0000;
			opb_q <= 32'h0000_0000;
			cond_q <= 32'h0000_0000;
			count_q <= 32'h0000_0000;
			link_q <= 32'h0000_0000;
			xer_q <= 32'h0000_0000;
			pred_q <= 32'h0000_0000;
			super_q <= 1'b1;
			stat_q <= 8'h00;
		end else begin
			if (acc_w) begin
				case (paddr)
					`IBMO_ADDR_CTRL: begin
						super_q <= pwdata[`IBMO_CTRL_SUPER];
						if (pwdata[`IBMO_CTRL_FLUSH]) begin
							stat_q <= 8'h00;
						end
					end
					`IBMO_ADDR_INSTR: instr_q <= pwdata;
					`IBMO_ADDR_OPA: opa_q <= pwdata;
					`IBMO_ADDR_OPB: opb_q <= pwdata;
					`IBMO_ADDR_COND: cond_q <= pwdata;
					`IBMO_ADDR_COUNT: count_q <= pwdata;
					`IBMO_ADDR_LINK: link_q <= pwdata;
					`IBMO_ADDR_XER: xer_q <= pwdata;
					`IBMO_ADDR_PRED: pred_q <= pwdata;
					default: ;
				endcase
			end
			if (go) begin
				stat_q[`IBMO_STAT_TRAP] <= trap_hit;
				stat_q[`IBMO_STAT_SYSCALL] <= (cls == IBMO_C_SYSCALL);
				stat_q[`IBMO_STAT_PRIV] <= priv_fault;
				stat_q[`IBMO_STAT_MISPRED] <= cls inside {IBMO_C_BRANCH, IBMO_C_BRCOND,
					IBMO_C_BRLINK, IBMO_C_BRCOUNT} && !target_ok;
				stat_q[`IBMO_STAT_TLBONE] <= (cls == IBMO_C_TLBONE) && super_q;
				stat_q[`IBMO_STAT_TLBALL] <= (cls == IBMO_C_TLBALL) && super_q;
				if (cls == IBMO_C_CRLOGIC) begin
					cond_q <= cond_d;
				end
				if (cls == IBMO_C_BRCOND || cls == IBMO_C_BRLINK) begin
					count_q <= count_d;
				end
				if (cls inside {IBMO_C_BRANCH, IBMO_C_BRCOND} && instr_q[0]) begin
					link_q <= fetch_q + 32'h0000_0004;
				end
				if (cls == IBMO_C_STORECOND) begin
					cond_q[31:28] <= {2'b00, resv_q, xer_q[31]};
				end
				if (cls == IBMO_C_RFI || cls == IBMO_C_RFCI || cls == IBMO_C_RFMCI ||
					cls == IBMO_C_RFDI) begin
					super_q <= super_q & priv_fault ? super_q : 1'b0;
				end else if (cls == IBMO_C_SYSCALL || trap_hit) begin
					super_q <= 1'b1;
				end
			end
			stat_q[`IBMO_STAT_RESV] <= resv_q;
			stat_q[`IBMO_STAT_SYNCWAIT] <= sync_block;
		end
	end

	// Read mux, registered output data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`IBMO_ADDR_CTRL: prdata <= {30'h0, super_q, 1'b0};
				`IBMO_ADDR_INSTR: prdata <= instr_q;
				`IBMO_ADDR_OPA: prdata <= opa_q;
				`IBMO_ADDR_OPB: prdata <= opb_q;
				`IBMO_ADDR_COND: prdata <= cond_q;
				`IBMO_ADDR_COUNT: prdata <= count_q;
				`IBMO_ADDR_LINK: prdata <= link_q;
				`IBMO_ADDR_STAT: prdata <= {24'h0, stat_q};
				`IBMO_ADDR_XER: prdata <= xer_q;
				`IBMO_ADDR_PRED: prdata <= pred_q;
				`IBMO_ADDR_FETCH: prdata <= fetch_q;
				`IBMO_ADDR_MEMOP: prdata <= {23'h0, mem_op};
				`IBMO_ADDR_CLASS: prdata <= {23'h0, fconv, 2'b00, cls};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Checks
	property p_order;
		@(posedge pclk) disable iff (!presetn) mem_req |-> $past(go) && $past(!priv_fault);
	endproperty
	a_order: assert property (p_order) else $error("memory op issued without go");
	property p_sync;
		@(posedge pclk) disable iff (!presetn) go && cls == IBMO_C_SYNC |-> outst_q == 4'h0;
	endproperty
	a_sync: assert property (p_sync) else $error("sync did not hold");
	property p_flush;
		@(posedge pclk) disable iff (!presetn) fetch_flush |-> $past(go) && !$past(target_ok);
	endproperty
	a_flush: assert property (p_flush) else $error("flush without mispredict");
	property p_trap;
		@(posedge pclk) disable iff (!presetn) go && trap_hit |=> stat_q[`IBMO_STAT_TRAP] && super_q;
	endproperty
	a_trap: assert property (p_trap) else $error("trap not taken");
	property p_sc;
		@(posedge pclk) disable iff (!presetn) go && cls == IBMO_C_SYSCALL |=> stat_q[1] && super_q;
	endproperty
	a_sc: assert property (p_sc) else $error("system call not taken");
	property p_priv;
		@(posedge pclk) disable iff (!presetn) go && !super_q &&
			cls inside {IBMO_C_MFMSR, IBMO_C_MTMSR} |=> stat_q[3];
	endproperty
	a_priv: assert property (p_priv) else $error("privilege fault missed");
	property p_resv;
		@(posedge pclk) disable iff (!presetn) go && cls == IBMO_C_STORECOND |=> !resv_q;
	endproperty
	a_resv: assert property (p_resv) else $error("reservation not cleared");
	property p_tlb;
		@(posedge pclk) disable iff (!presetn) go && cls == IBMO_C_TLBONE |=>
			stat_q[`IBMO_STAT_TLBONE] == $past(super_q);
	endproperty
	a_tlb: assert property (p_tlb) else $error("tlb invalidate in user mode");
endmodule

// ### hdl/ibmo_pkg.sv
// Types for the branch and memory-order decode core.
// Assumes the constants header sits beside it.
package ibmo_pkg;
	// Decoded instruction classes
	typedef enum logic [4:0] {
		IBMO_C_NONE, IBMO_C_BRANCH, IBMO_C_BRCOND, IBMO_C_BRLINK, IBMO_C_BRCOUNT,
		IBMO_C_CRLOGIC, IBMO_C_TRAPREG, IBMO_C_TRAPIMM, IBMO_C_SYSCALL,
		IBMO_C_RFI, IBMO_C_RFCI, IBMO_C_RFMCI, IBMO_C_RFDI, IBMO_C_MFSPR, IBMO_C_MTSPR,
		IBMO_C_MFMSR, IBMO_C_MTMSR, IBMO_C_SYNC, IBMO_C_ISYNC, IBMO_C_DCACHE,
		IBMO_C_TLBONE, IBMO_C_TLBALL, IBMO_C_LOAD, IBMO_C_STORE, IBMO_C_LOADRES,
		IBMO_C_STORECOND, IBMO_C_FCMPO, IBMO_C_FCMPU, IBMO_C_FSEL, IBMO_C_FCONV,
		IBMO_C_FRSP, IBMO_C_ILLEGAL
	} ibmo_class_e;
	typedef enum logic [1:0] {IBMO_SZ_BYTE, IBMO_SZ_HALF, IBMO_SZ_WORD} ibmo_size_e;
	// Load/store attributes grouped for the memory side
	typedef struct packed {
		logic valid;
		logic store;
		ibmo_size_e size;
		logic sign_ext;
		logic byte_rev;
		logic update;
		logic indexed;
		logic reserve;
	} ibmo_memop_s;
	// Floating-point conversion attributes
	typedef struct packed {
		logic dword;
		logic to_zero;
	} ibmo_fconv_s;
endpackage

// ### hdl/ibmo_regs.svh
// Constants for the branch and memory-order decode core.
// Assumes inclusion by the core and the test bench only.
`ifndef IBMO_REGS_SVH
`define IBMO_REGS_SVH
`define IBMO_ADDR_CTRL 12'h000
`define IBMO_ADDR_INSTR 12'h004
`define IBMO_ADDR_OPA 12'h008
`define IBMO_ADDR_OPB 12'h00C
`define IBMO_ADDR_COND 12'h010
`define IBMO_ADDR_COUNT 12'h014
`define IBMO_ADDR_LINK 12'h018
`define IBMO_ADDR_STAT 12'h01C
`define IBMO_ADDR_XER 12'h020
`define IBMO_ADDR_PRED 12'h024
`define IBMO_ADDR_FETCH 12'h028
`define IBMO_ADDR_MEMOP 12'h02C
`define IBMO_ADDR_CLASS 12'h030
`define IBMO_CTRL_GO 0
`define IBMO_CTRL_SUPER 1
`define IBMO_CTRL_FLUSH 2
`define IBMO_STAT_TRAP 0
`define IBMO_STAT_SYSCALL 1
`define IBMO_STAT_MISPRED 2
`define IBMO_STAT_PRIV 3
`define IBMO_STAT_RESV 4
`define IBMO_STAT_SYNCWAIT 5
`define IBMO_STAT_TLBALL 6
`define IBMO_STAT_TLBONE 7
`define IBMO_RST_FETCH 32'h0000_0100
`define IBMO_SPR_XER 10'h001
`define IBMO_SPR_LINK 10'h008
`define IBMO_SPR_COUNT 10'h009
`define IBMO_SPR_TB_USER 10'h10C
`define IBMO_SPR_TB_SUPER 10'h11C
`define IBMO_OUTSTANDING_MAX 4'h8
`endif

// ### verif/ibmo_core_test.sv
// Self-checking bench: drives the core over APB and checks status and memory side.
// Assumes the memory model beside it and zero-wait APB answers.
`include "ibmo_regs.svh"
module ibmo_core_test import ibmo_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [31:0] ins, a, b, cnd, cnt;
		logic [3:0] ctl;
		logic [7:0] m, x;
	} ibmo_row_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic mem_req, mem_done, fetch_flush, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, mem_addr, fetch_addr, r, c0, last_addr;
	logic [7:0] pending;
	ibmo_memop_s mem_op, last_op;
	ibmo_row_s rows [0:19];
	logic [31:0] lins [0:5];
	ibmo_memop_s lop [0:5];
	logic [31:0] cins [0:12];
	ibmo_class_e ccls [0:12];
	logic [9:0] crxo [0:7];
	int err_count, comparisons, n_req, n_flush, i;

	ibmo_core ibmo_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_req(mem_req), .mem_op(mem_op), .mem_addr(mem_addr),
		.mem_done(mem_done), .fetch_addr(fetch_addr), .fetch_flush(fetch_flush));
	ibmo_mem_model ibmo_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
		.slow(slow), .mem_done(mem_done), .pending(pending));

	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Count one-cycle pulses so no scenario has to hit their exact cycle
	always @(posedge pclk) begin
		if (mem_req === 1'b1) begin
			n_req++;
			last_op = mem_op;
			last_addr = mem_addr;
		end
		if (fetch_flush === 1'b1) n_flush++;
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		err_count++;
		test_done();
	end

	task automatic test_done();
		$display("Mismatches %0d, comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
			err_count++;
		end
	endtask
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			test_done();
		end
	endtask
	// Load operands, set mode first: go checks the mode already held
	task automatic ex(input logic [31:0] ins, a, b, input logic [3:0] ctl);
		apb(1'b1, `IBMO_ADDR_INSTR, ins);
		apb(1'b1, `IBMO_ADDR_OPA, a);
		apb(1'b1, `IBMO_ADDR_OPB, b);
		apb(1'b1, `IBMO_ADDR_CTRL, {28'h0000000, ctl & 4'hE});
		apb(1'b1, `IBMO_ADDR_CTRL, {28'h0000000, ctl});
		repeat (3) @(posedge pclk);
	endtask
	function automatic logic [31:0] spr(input logic [9:0] s);
		return {11'h000, s[4:0], s[9:5], 11'h000};
	endfunction
	function automatic ibmo_memop_s mo(input logic s, input ibmo_size_e z, input logic [4:0] f);
		return {1'b1, s, z, f};
	endfunction

	// Main sequence
	initial begin
		{psel, penable, pwrite, presetn, slow} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		rows = '{
			'{32'h44000002, 0, 0, 0, 0, 4'h1, 8'h0B, 8'h02},
			'{32'h7C0000A6, 0, 0, 0, 0, 4'h1, 8'h08, 8'h08},
			'{32'h7C0000A6, 0, 0, 0, 0, 4'h3, 8'h08, 8'h00},
			'{32'h7C0003A6 | spr(`IBMO_SPR_XER), 0, 0, 0, 0, 4'h1, 8'h08, 8'h00},
			'{32'h7C0002A6 | spr(`IBMO_SPR_TB_USER), 0, 0, 0, 0, 4'h1, 8'h08, 8'h00},
			'{32'h7C0002A6 | spr(`IBMO_SPR_TB_SUPER), 0, 0, 0, 0, 4'h1, 8'h08, 8'h08},
			'{32'h4C000064, 0, 0, 0, 0, 4'h1, 8'h08, 8'h08},
			'{32'h7C800008, 5, 5, 0, 0, 4'h3, 8'h01, 8'h01},
			'{32'h7C800008, 5, 6, 0, 0, 4'h3, 8'h01, 8'h00},
			'{32'h7E000008, 1, -1, 0, 0, 4'h3, 8'h01, 8'h00},
			'{32'h7C400008, 1, -1, 0, 0, 4'h3, 8'h01, 8'h01},
			'{32'h7D000008, 5, 3, 0, 0, 4'h3, 8'h01, 8'h01},
			'{32'h7C200008, 1, -1, 0, 0, 4'h3, 8'h01, 8'h00},
			'{32'h0C800005, 5, 0, 0, 0, 4'h3, 8'h01, 8'h01},
			'{32'h7C0002E4, 0, 0, 0, 0, 4'h3, 8'h40, 8'h40},
			'{32'h7C000264, 0, 0, 0, 0, 4'h3, 8'h80, 8'h80},
			'{32'h41800000, 0, 0, -1, 0, 4'h3, 8'h04, 8'h04},
			'{32'h41800000, 0, 0, 0, 0, 4'h3, 8'h04, 8'h00},
			'{32'h42000000, 0, 0, 0, 1, 4'h3, 8'h04, 8'h00},
			'{32'h42000000, 0, 0, 0, 2, 4'h3, 8'h04, 8'h04}};
		lins = '{32'h88000000, 32'hA8000000, 32'h84000000, 32'h7C00062C, 32'h7C00002E,
			32'h7C000028};
		lop = '{mo(0, IBMO_SZ_BYTE, 5'h00), mo(0, IBMO_SZ_HALF, 5'h10),
			mo(0, IBMO_SZ_WORD, 5'h04), mo(0, IBMO_SZ_HALF, 5'h0A),
			mo(0, IBMO_SZ_WORD, 5'h02), mo(0, IBMO_SZ_WORD, 5'h03)};
		cins = '{32'h4C000066, 32'h4C00004C, 32'h4C00004E, 32'hFC000040, 32'hFC000000,
			32'hFC00002E, 32'hFC00001C, 32'hFC00001E, 32'hFC00065C, 32'hFC00065E,
			32'hFC000018, 32'h7C0000AC, 32'h7C0004AC};
		ccls = '{IBMO_C_RFCI, IBMO_C_RFMCI, IBMO_C_RFDI, IBMO_C_FCMPO, IBMO_C_FCMPU,
			IBMO_C_FSEL, IBMO_C_FCONV, IBMO_C_FCONV, IBMO_C_FCONV, IBMO_C_FCONV,
			IBMO_C_FRSP, IBMO_C_DCACHE, IBMO_C_SYNC};
		crxo = '{10'h101, 10'h1C1, 10'h0C1, 10'h0E1, 10'h021, 10'h121, 10'h081, 10'h1A1};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `IBMO_ADDR_FETCH, 0);
		chk("fetch reg", `IBMO_RST_FETCH, r);
		chk("fetch_addr", `IBMO_RST_FETCH, fetch_addr);
		apb(1'b0, 12'h034, 0);
		chk("pslverr", 1, {31'h0, e});
		apb(1'b1, `IBMO_ADDR_XER, 32'hA5A55A5A);
		apb(1'b0, `IBMO_ADDR_XER, 0);
		chk("xer", 32'hA5A55A5A, r);
		// Status, privilege, trap and branch cases
		for (i = 0; i < 20; i++) begin
			apb(1'b1, `IBMO_ADDR_COND, rows[i].cnd);
			apb(1'b1, `IBMO_ADDR_COUNT, rows[i].cnt);
			apb(1'b1, `IBMO_ADDR_PRED, 0);
			c0 = 32'(n_flush);
			ex(rows[i].ins, rows[i].a, rows[i].b, rows[i].ctl);
			apb(1'b0, `IBMO_ADDR_STAT, 0);
			chk("status", {24'h0, rows[i].x}, r & {24'h0, rows[i].m});
			chk("flush", {31'h0, rows[i].m[2] & rows[i].x[2]}, 32'(n_flush) - c0);
		end
		apb(1'b0, `IBMO_ADDR_COUNT, 0);
		chk("count", 1, r);
		// Prediction steers fetch; right guess no recovery, wrong guess refetches
		apb(1'b1, `IBMO_ADDR_PRED, 32'h0000_0041);
		@(posedge pclk);
		chk("fetch steer", 32'h40, fetch_addr);
		c0 = 32'(n_flush);
		ex(32'h48000040, 0, 0, 4'h3);
		apb(1'b0, `IBMO_ADDR_STAT, 0);
		chk("good predict", 0, r & 32'h0000_0004);
		chk("no flush", c0, 32'(n_flush));
		apb(1'b1, `IBMO_ADDR_PRED, 32'h0000_0081);
		ex(32'h48000040, 0, 0, 4'h3);
		chk("refetch", 32'h40, fetch_addr);
		chk("flush once", c0 + 1, 32'(n_flush));
		// Decode classes, condition logic included
		for (i = 0; i < 21; i++) begin
			ex(i < 13 ? cins[i] : 32'h4C000000 | {21'h0, crxo[i - 13], 1'b0}, 0, 0, 4'h3);
			apb(1'b0, `IBMO_ADDR_CLASS, 0);
			c0 = i < 13 ? 32'(ccls[i]) : 32'(IBMO_C_CRLOGIC);
			chk("class", c0, r & 32'h0000_001F);
			if (i >= 6 && i < 10) chk("fconv", 32'(i - 6), {30'h0, r[8:7]});
		end
		// Eight ops chained on bit 0 from clear end with it set
		apb(1'b0, `IBMO_ADDR_COND, 0);
		chk("cr logic", 32'h8000_0000, r);
		// Load forms, ending with the reserving load
		for (i = 0; i < 6; i++) begin
			c0 = 32'(n_req);
			ex(lins[i], 32'h40, 32'h4, 4'h3);
			chk("mem_req", c0 + 1, 32'(n_req));
			chk("mem_op", 32'(lop[i]), 32'(last_op));
			chk("mem_addr", i < 3 ? 32'h40 : 32'h44, last_addr);
		end
		c0 = 32'(n_req);
		ex(32'h7C00012D, 32'h40, 32'h4, 4'h3);
		chk("stcx req", c0 + 1, 32'(n_req));
		chk("stcx store", 1, {31'h0, last_op.store});
		apb(1'b0, `IBMO_ADDR_COND, 0);
		chk("stcx ok", 1, {31'h0, r[29]});
		ex(32'h7C00012D, 32'h40, 32'h4, 4'h3);
		chk("stcx no resv", c0 + 1, 32'(n_req));
		apb(1'b0, `IBMO_ADDR_COND, 0);
		chk("stcx fail", 0, {31'h0, r[29]});
		// Barrier with slow memory: sync start refused until drained
		slow <= 1'b1;
		ex(32'h80000000, 32'h80, 0, 4'h3);
		ex(32'h80000000, 32'h84, 0, 4'h3);
		ex(32'h7C0000AC, 0, 0, 4'h3);
		ex(32'h7C0004AC, 0, 0, 4'h3);
		apb(1'b0, `IBMO_ADDR_STAT, 0);
		chk("sync wait", 32'h20, r & 32'h60);
		ex(32'h7C0002E4, 0, 0, 4'h3);
		for (i = 0; i < 1000 && pending !== 8'h00; i++) @(posedge pclk);
		if (pending !== 8'h00) begin
			err_count++;
			test_done();
		end
		slow <= 1'b0;
		ex(32'h7C0004AC, 0, 0, 4'h3);
		ex(32'h7C0002E4, 0, 0, 4'h3);
		apb(1'b0, `IBMO_ADDR_STAT, 0);
		chk("after drain", 32'h40, r & 32'h60);
		test_done();
	end
endmodule

// ### verif/ibmo_mem_model.sv
// Memory-side model: acknowledges each access after a short or long delay.
// Assumes one mem_req pulse per access and a single pclk domain.
module ibmo_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mem_req,
	input wire logic slow,
	output logic mem_done,
	output logic [7:0] pending
);
	logic [7:0] wait_q;
	logic issue;
	// One acknowledgement per open access, never early
	assign issue = (pending != 8'h00) && (wait_q == 8'h00);
	// Long delay keeps accesses open so ordering barriers can be seen waiting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= 8'h00;
			wait_q <= 8'h00;
			mem_done <= 1'b0;
		end else begin
			mem_done <= issue;
			pending <= pending + {7'h00, mem_req} - {7'h00, issue};
			if (issue) begin
				wait_q <= slow ? 8'hC8 : 8'h01;
			end else if (wait_q != 8'h00) begin
				wait_q <= wait_q - 8'h01;
			end
		end
	end
endmodule
